// ==== hdl/ls_sweep_pkg.sv ====
`include "ls_sweep_regs.svh"
package ls_sweep_pkg;
   typedef enum logic [1:0] {
      LS_TRG_BUS = 2'b00,
      LS_TRG_IMM = 2'b01,
      LS_TRG_EXT = 2'b10,
      LS_TRG_KEY = 2'b11
   } ls_trig_src_t;

   typedef enum logic [2:0] {
      LS_ST_IDLE  = 3'b000,
      LS_ST_ARMED = 3'b001,
      LS_ST_HOLD  = 3'b010,
      LS_ST_LOAD  = 3'b011
   } ls_state_t;

   typedef struct packed {
      logic [`LS_FW-1:0] start_freq;
      logic [`LS_FW-1:0] stop_freq;
      logic [`LS_PW-1:0] start_pow;
      logic [`LS_PW-1:0] stop_pow;
      logic [`LS_CW-1:0] points;
      logic [`LS_DW-1:0] dwell;
   } ls_step_cfg_t;

   typedef struct packed {
      logic              en;
      logic              clr;
      logic [1:0]        sel;
      logic [`LS_FW-1:0] data;
   } ls_list_wr_t;
endpackage

// ==== hdl/ls_sweep_regs.svh ====
`ifndef LS_SWEEP_REGS_SVH
`define LS_SWEEP_REGS_SVH

`define LS_FW            32
`define LS_PW            16
`define LS_DW            24
`define LS_DEPTH         16
`define LS_IW            4
`define LS_CW            5
`define LS_CLK_NS        10
`define LS_DWELL_UNIT_NS 1000
`define LS_TICK_CYC      (`LS_DWELL_UNIT_NS / `LS_CLK_NS)
`define LS_MAN_RST       5'h01
`define LS_LIST_DWELL    2'h0
`define LS_LIST_FREQ     2'h1
`define LS_LIST_POW      2'h2
`endif

// ==== hdl/ls_sweep_seq.sv ====
`timescale 1ns/10ps
`include "ls_sweep_regs.svh"
module ls_sweep_seq
   import ls_sweep_pkg::*;
#(
   parameter int DEPTH = `LS_DEPTH
)(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              por_preset,
   input  wire ls_list_wr_t       list_wr,
   input  wire ls_step_cfg_t      step_cfg,
   input  wire logic              load_from_step,
   input  wire logic              type_step,
   input  wire logic              dwell_type_step,
   input  wire logic              dir_down,
   input  wire logic              mode_manual,
   input  wire ls_trig_src_t      trig_src,
   input  wire logic              freq_en,
   input  wire logic              pow_en,
   input  wire logic              initiate,
   input  wire logic              sweep_trig,
   input  wire logic              bus_trig,
   input  wire logic              ext_trig,
   input  wire logic              key_trig,
   input  wire logic              man_wr,
   input  wire logic [`LS_CW-1:0] man_point,
   output logic [`LS_FW-1:0]      freq_out_reg,
   output logic [`LS_PW-1:0]      pow_out_reg,
   output logic [`LS_CW-1:0]      cur_point_reg,
   output logic [`LS_CW-1:0]      man_point_reg,
   output logic                   man_err_reg,
   output logic                   busy_reg,
   output logic                   done_reg,
   output logic [`LS_CW-1:0]      dwell_cnt_reg,
   output logic [`LS_CW-1:0]      freq_cnt_reg,
   output logic [`LS_CW-1:0]      pow_cnt_reg
);
   localparam int TICK = `LS_TICK_CYC;

   ////////////////////////////////////////////////////////////////////////////////
   // List storage, no reset so contents survive nrst
   logic [`LS_DW-1:0] dwell_list_store [DEPTH];
   logic [`LS_FW-1:0] freq_list_store  [DEPTH];
   logic [`LS_PW-1:0] power_list_store [DEPTH];
   ls_state_t         state_reg;
   logic [`LS_IW-1:0] idx_reg;
   logic [`LS_CW-1:0] load_k_reg;
   logic [`LS_DW-1:0] rem_reg;
   logic [7:0]        pre_reg;
   logic              point_trig;
   logic              advance;
   logic              last_pt;
   logic [`LS_CW-1:0] npts;
   logic [`LS_CW-1:0] longest;
   logic [`LS_IW-1:0] pt_idx;
   logic [`LS_FW-1:0] pt_freq;
   logic [`LS_PW-1:0] pt_pow;
   logic [`LS_DW-1:0] pt_dwell;
   logic [`LS_FW-1:0] ld_freq;
   logic [`LS_PW-1:0] ld_pow;
   logic [`LS_FW-1:0] pt_pow_full;
   logic [`LS_FW-1:0] ld_pow_full;
   logic              fresh_reg;

   function automatic logic [`LS_FW-1:0] interp(input logic [`LS_FW-1:0] a,
                                               input logic [`LS_FW-1:0] b,
                                               input logic [`LS_CW-1:0] k,
                                               input logic [`LS_CW-1:0] n);
      logic signed [63:0] diff;
      logic signed [63:0] r;
      diff = $signed({32'h0000_0000, b}) - $signed({32'h0000_0000, a});
      r = $signed({32'h0000_0000, a});
      if (n > 5'h01) begin
         r = r + (diff * $signed({59'h0, k})) / $signed({59'h0, n - 5'h01});
      end
      return r[`LS_FW-1:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Point selection
   always_comb begin
      longest = 5'h00;
      if (freq_en && freq_cnt_reg > longest) longest = freq_cnt_reg;
      if (pow_en && pow_cnt_reg > longest) longest = pow_cnt_reg;
      npts     = type_step ? step_cfg.points : longest;
      last_pt  = dir_down ? (idx_reg == '0) : ({1'b0, idx_reg} == npts - 5'h01);
      pt_idx   = mode_manual ? man_point_reg[`LS_IW-1:0] - 4'h1 : idx_reg;
      pt_freq  = type_step ? interp(step_cfg.start_freq, step_cfg.stop_freq,
                                    {1'b0, pt_idx}, step_cfg.points)
                           : freq_list_store[pt_idx];
      pt_pow_full = interp({16'h0000, step_cfg.start_pow}, {16'h0000, step_cfg.stop_pow},
                           {1'b0, pt_idx}, step_cfg.points);
      pt_pow   = type_step ? pt_pow_full[`LS_PW-1:0]
                           : power_list_store[pt_idx];
      pt_dwell = dwell_type_step ? step_cfg.dwell : dwell_list_store[pt_idx];
      ld_freq  = interp(step_cfg.start_freq, step_cfg.stop_freq, load_k_reg, step_cfg.points);
      ld_pow_full = interp({16'h0000, step_cfg.start_pow}, {16'h0000, step_cfg.stop_pow},
                           load_k_reg, step_cfg.points);
      ld_pow   = ld_pow_full[`LS_PW-1:0];
   end

   always_comb begin
      unique case (trig_src)
         LS_TRG_BUS: point_trig = bus_trig;
         LS_TRG_IMM: point_trig = 1'b0;
         LS_TRG_EXT: point_trig = ext_trig;
         LS_TRG_KEY: point_trig = key_trig;
      endcase
   end

   // Triggers count only while holding a point of a started sweep
   assign advance = (state_reg == LS_ST_HOLD) &&
                    ((trig_src == LS_TRG_IMM) ? (rem_reg == '0 && !fresh_reg)
                                              : point_trig);

   ////////////////////////////////////////////////////////////////////////////////
   // List contents and counts
   always_ff @(posedge clk) begin
      if (state_reg == LS_ST_LOAD) begin
         freq_list_store[load_k_reg[`LS_IW-1:0]]  <= ld_freq;
         power_list_store[load_k_reg[`LS_IW-1:0]] <= ld_pow;
         dwell_list_store[load_k_reg[`LS_IW-1:0]] <= step_cfg.dwell;
      end else if (list_wr.en && !list_wr.clr) begin
         if (list_wr.sel == `LS_LIST_DWELL && dwell_cnt_reg < DEPTH[`LS_CW-1:0])
            dwell_list_store[dwell_cnt_reg[`LS_IW-1:0]] <= list_wr.data[`LS_DW-1:0];
         if (list_wr.sel == `LS_LIST_FREQ && freq_cnt_reg < DEPTH[`LS_CW-1:0])
            freq_list_store[freq_cnt_reg[`LS_IW-1:0]] <= list_wr.data;
         if (list_wr.sel == `LS_LIST_POW && pow_cnt_reg < DEPTH[`LS_CW-1:0])
            power_list_store[pow_cnt_reg[`LS_IW-1:0]] <= list_wr.data[`LS_PW-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (por_preset) begin
         dwell_cnt_reg <= '0;
         freq_cnt_reg  <= '0;
         pow_cnt_reg   <= '0;
      end else if (state_reg == LS_ST_LOAD) begin
         dwell_cnt_reg <= step_cfg.points;
         freq_cnt_reg  <= step_cfg.points;
         pow_cnt_reg   <= step_cfg.points;
      end else if (list_wr.en) begin
         if (list_wr.sel == `LS_LIST_DWELL)
            dwell_cnt_reg <= list_wr.clr ? '0 :
                             dwell_cnt_reg + {4'h0, dwell_cnt_reg < DEPTH[`LS_CW-1:0]};
         if (list_wr.sel == `LS_LIST_FREQ)
            freq_cnt_reg <= list_wr.clr ? '0 :
                            freq_cnt_reg + {4'h0, freq_cnt_reg < DEPTH[`LS_CW-1:0]};
         if (list_wr.sel == `LS_LIST_POW)
            pow_cnt_reg <= list_wr.clr ? '0 :
                           pow_cnt_reg + {4'h0, pow_cnt_reg < DEPTH[`LS_CW-1:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sweep sequencing
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg  <= LS_ST_IDLE;
         idx_reg    <= '0;
         load_k_reg <= '0;
         done_reg   <= 1'b0;
         busy_reg   <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         unique case (state_reg)
            LS_ST_IDLE: begin
               if (load_from_step) begin
                  load_k_reg <= '0;
                  state_reg  <= (step_cfg.points == '0) ? LS_ST_IDLE : LS_ST_LOAD;
               end else if (initiate && !mode_manual) begin
                  state_reg <= LS_ST_ARMED;
                  busy_reg  <= 1'b1;
               end
            end
            LS_ST_LOAD: begin
               load_k_reg <= load_k_reg + 5'h01;
               if (load_k_reg + 5'h01 >= step_cfg.points) state_reg <= LS_ST_IDLE;
            end
            LS_ST_ARMED: begin
               if (sweep_trig) begin
                  if (npts == '0) begin
                     state_reg <= LS_ST_IDLE;
                     busy_reg  <= 1'b0;
                     done_reg  <= 1'b1;
                  end else begin
                     idx_reg   <= dir_down ? 4'(npts - 5'h01) : '0;
                     state_reg <= LS_ST_HOLD;
                  end
               end
            end
            LS_ST_HOLD: begin
               if (advance) begin
                  if (last_pt) begin
                     state_reg <= LS_ST_IDLE;
                     busy_reg  <= 1'b0;
                     done_reg  <= 1'b1;
                  end else begin
                     idx_reg <= dir_down ? idx_reg - 4'h1 : idx_reg + 4'h1;
                  end
               end
            end
            default: state_reg <= LS_ST_IDLE;
         endcase
      end
   end

   // First cycle of a point: the index has settled, so its own dwell is reloaded
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fresh_reg <= 1'b1;
      end else begin
         fresh_reg <= (state_reg != LS_ST_HOLD) || advance;
      end
   end

   // Dwell timer restarts on every point entry
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rem_reg <= '0;
         pre_reg <= '0;
      end else if (state_reg != LS_ST_HOLD || advance || fresh_reg) begin
         rem_reg <= pt_dwell;
         pre_reg <= '0;
      end else if (rem_reg != '0) begin
         if (pre_reg == 8'(TICK - 1)) begin
            pre_reg <= '0;
            rem_reg <= rem_reg - 24'h00_0001;
         end else begin
            pre_reg <= pre_reg + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Manual point and outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         man_point_reg <= `LS_MAN_RST;
         man_err_reg   <= 1'b0;
      end else begin
         man_err_reg <= 1'b0;
         if (man_wr) begin
            if (man_point > longest) begin
               man_point_reg <= (longest == '0) ? `LS_MAN_RST : longest;
               man_err_reg   <= 1'b1;
            end else begin
               man_point_reg <= (man_point == '0) ? `LS_MAN_RST : man_point;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         freq_out_reg  <= '0;
         pow_out_reg   <= '0;
         cur_point_reg <= '0;
      end else if (mode_manual || state_reg == LS_ST_HOLD) begin
         if (freq_en) freq_out_reg <= pt_freq;
         if (pow_en) pow_out_reg <= pt_pow;
         cur_point_reg <= {1'b0, pt_idx} + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [31:0] held_reg;
   logic [`LS_DW-1:0] entry_dwell_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         held_reg        <= '0;
         entry_dwell_reg <= '0;
      end else if (state_reg != LS_ST_HOLD || advance) begin
         held_reg <= '0;
      end else begin
         held_reg <= held_reg + 32'h0000_0001;
         if (fresh_reg) begin
            entry_dwell_reg <= pt_dwell;
         end
      end
   end

   sequence s_adv_mid;
      advance && !last_pt && !mode_manual;
   endsequence
   sequence s_adv_last;
      advance && last_pt;
   endsequence

   property p_dwell_min;
      @(posedge clk) disable iff (!nrst)
      advance && trig_src == LS_TRG_IMM |-> held_reg >= 32'(entry_dwell_reg) * TICK;
   endproperty
   a_dwell_min: assert property (p_dwell_min) else $error("dwell cut short");

   property p_trig_only;
      @(posedge clk) disable iff (!nrst)
      state_reg == LS_ST_HOLD && trig_src != LS_TRG_IMM && !point_trig
      |=> $stable(idx_reg) && state_reg == LS_ST_HOLD;
   endproperty
   a_trig_only: assert property (p_trig_only) else $error("advance without trigger");

   property p_dwell_src;
      @(posedge clk) disable iff (!nrst)
      state_reg == LS_ST_HOLD && fresh_reg && dwell_type_step
      |=> rem_reg == $past(step_cfg.dwell);
   endproperty
   a_dwell_src: assert property (p_dwell_src) else $error("wrong dwell source");

   property p_freq_list;
      @(posedge clk) disable iff (!nrst)
      state_reg == LS_ST_HOLD && !mode_manual && !type_step && freq_en
      |=> freq_out_reg == freq_list_store[$past(idx_reg)];
   endproperty
   a_freq_list: assert property (p_freq_list) else $error("freq not from list");

   property p_pow_list;
      @(posedge clk) disable iff (!nrst)
      state_reg == LS_ST_HOLD && !mode_manual && !type_step && pow_en
      |=> pow_out_reg == power_list_store[$past(idx_reg)];
   endproperty
   a_pow_list: assert property (p_pow_list) else $error("power not from list");

   property p_no_early;
      @(posedge clk) disable iff (!nrst)
      state_reg inside {LS_ST_IDLE, LS_ST_ARMED} |-> ##1 $stable(idx_reg) || $past(sweep_trig);
   endproperty
   a_no_early: assert property (p_no_early) else $error("early point trigger");

   property p_step_one;
      @(posedge clk) disable iff (!nrst)
      s_adv_mid |=> idx_reg == ($past(dir_down) ? $past(idx_reg) - 4'h1 : $past(idx_reg) + 4'h1);
   endproperty
   a_step_one: assert property (p_step_one) else $error("index step wrong");

   property p_done;
      @(posedge clk) disable iff (!nrst)
      s_adv_last |=> done_reg && !busy_reg && state_reg == LS_ST_IDLE ##1 !done_reg;
   endproperty
   a_done: assert property (p_done) else $error("sweep did not complete");

   property p_clamp;
      @(posedge clk) disable iff (!nrst)
      man_wr && man_point > longest && longest != '0
      |=> man_err_reg && man_point_reg == $past(longest);
   endproperty
   a_clamp: assert property (p_clamp) else $error("manual point not clamped");
endmodule

// ==== verif/ls_trig_src_model.sv ====
`timescale 1ns/10ps
module ls_trig_src_model (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic fire,
   output logic      ext_trig
);
   logic [3:0] wait_cnt;
   logic       pend;

   ////////////////////////////////////////////////////////////////////////////////
   // External trigger source: one clean pulse 1..8 cycles after a request
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend     <= 1'b0;
         wait_cnt <= 4'h0;
         ext_trig <= 1'b0;
      end else begin
         ext_trig <= 1'b0;
         if (fire && !pend) begin
            pend     <= 1'b1;
            wait_cnt <= 4'($urandom_range(7, 0));
         end else if (pend && wait_cnt == 4'h0) begin
            pend     <= 1'b0;
            ext_trig <= 1'b1;
         end else if (pend) begin
            wait_cnt <= wait_cnt - 4'h1;
         end
      end
   end
endmodule

// ==== verif/tb_list_step_sweep_sequencer.sv ====
`timescale 1ns/10ps
`include "ls_sweep_regs.svh"
module tb_list_step_sweep_sequencer;
   import ls_sweep_pkg::*;
   logic clk, nrst, por_preset, load_from_step, type_step, dwell_type_step, dir_down;
   logic mode_manual, freq_en, pow_en, initiate, sweep_trig, bus_trig, ext_trig;
   logic key_trig, man_wr, ext_fire, man_err_reg, busy_reg, done_reg, seen;
   ls_list_wr_t list_wr;
   ls_step_cfg_t step_cfg;
   ls_trig_src_t trig_src;
   logic [`LS_CW-1:0] man_point, cur_point_reg, man_point_reg;
   logic [`LS_CW-1:0] dwell_cnt_reg, freq_cnt_reg, pow_cnt_reg;
   logic [`LS_FW-1:0] freq_out_reg, fstep;
   logic [`LS_PW-1:0] pow_out_reg, pstep;
   logic [31:0] ef [4];
   logic [15:0] ep [4];
   int mind [4];
   int fails, checked, cyc;

   ls_sweep_seq dut_u (.clk(clk), .nrst(nrst), .por_preset(por_preset), .list_wr(list_wr),
      .step_cfg(step_cfg), .load_from_step(load_from_step), .type_step(type_step),
      .dwell_type_step(dwell_type_step), .dir_down(dir_down), .mode_manual(mode_manual),
      .trig_src(trig_src), .freq_en(freq_en), .pow_en(pow_en), .initiate(initiate),
      .sweep_trig(sweep_trig), .bus_trig(bus_trig), .ext_trig(ext_trig),
      .key_trig(key_trig), .man_wr(man_wr), .man_point(man_point),
      .freq_out_reg(freq_out_reg), .pow_out_reg(pow_out_reg), .cur_point_reg(cur_point_reg),
      .man_point_reg(man_point_reg), .man_err_reg(man_err_reg), .busy_reg(busy_reg),
      .done_reg(done_reg), .dwell_cnt_reg(dwell_cnt_reg), .freq_cnt_reg(freq_cnt_reg),
      .pow_cnt_reg(pow_cnt_reg));
   ls_trig_src_model part_u (.clk(clk), .nrst(nrst), .fire(ext_fire), .ext_trig(ext_trig));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc++;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("Checks: %0d, mismatches: %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic lw(input logic [1:0] sel, input logic [31:0] d);
      list_wr = '{en: 1'b1, clr: 1'b0, sel: sel, data: d};
      tick;
      list_wr.en = 1'b0;
      tick;
   endtask
   // Point trigger from the chosen source; external waits for the partner's pulse
   task automatic fire(input ls_trig_src_t s);
      int w;
      bus_trig = (s == LS_TRG_BUS);
      key_trig = (s == LS_TRG_KEY);
      ext_fire = (s == LS_TRG_EXT);
      tick;
      {bus_trig, key_trig, ext_fire} = 3'h0;
      for (w = 0; w < 12 && s == LS_TRG_EXT && !ext_trig; w++) tick;
      if (s == LS_TRG_EXT) tick;
   endtask
   task automatic sweep(input ls_trig_src_t s, input logic down);
      int k, idx, w, lim, tprev, pidx;
      trig_src = s;
      dir_down = down;
      lim = (s == LS_TRG_IMM) ? 1500 : 20;
      initiate = 1'b1;
      tick;
      initiate = 1'b0;
      tick;
      chk(32'(busy_reg), 32'h1);
      fire(s);
      sweep_trig = 1'b1;
      tick;
      sweep_trig = 1'b0;
      repeat (2) tick;
      for (k = 0; k < 4; k++) begin
         idx = down ? 3 - k : k;
         for (w = 0; w < lim && cur_point_reg !== 5'(idx + 1); w++) tick;
         chk(32'(cur_point_reg), 32'(idx + 1));
         if (s == LS_TRG_IMM && k > 0)
            chk(32'((cyc - tprev) >= mind[pidx] * `LS_TICK_CYC), 32'h1);
         chk(freq_out_reg, ef[idx]);
         chk(32'(pow_out_reg), 32'(ep[idx]));
         tprev = cyc;
         pidx = idx;
         if (s != LS_TRG_IMM) fire(s);
      end
      seen = 1'b0;
      for (w = 0; w < lim && !seen; w++) begin
         seen = done_reg;
         tick;
      end
      chk(32'(seen), 32'h1);
      chk(32'(busy_reg), 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      fails++;
      final_report;
   end

   initial begin
      int i;
      void'($urandom(32'h7F3FD84D));
      {nrst, por_preset, load_from_step, type_step, dwell_type_step, dir_down} = 6'h0;
      {mode_manual, initiate, sweep_trig, bus_trig, key_trig, man_wr, ext_fire} = 7'h0;
      {freq_en, pow_en} = 2'h3;
      list_wr = '0;
      step_cfg = '0;
      trig_src = LS_TRG_IMM;
      man_point = 5'h00;
      repeat (2) @(posedge clk);
      #1 nrst = 1'b1;
      chk(32'(man_point_reg), 32'h1);
      por_preset = 1'b1;
      tick;
      por_preset = 1'b0;
      tick;
      chk(32'(dwell_cnt_reg), 32'h0);
      chk(32'(freq_cnt_reg), 32'h0);
      for (i = 0; i < 4; i++) begin
         ef[i] = $urandom;
         ep[i] = 16'($urandom);
         mind[i] = 1 + $urandom_range(2, 0);
         lw(`LS_LIST_FREQ, ef[i]);
         lw(`LS_LIST_POW, 32'(ep[i]));
         lw(`LS_LIST_DWELL, 32'(mind[i]));
      end
      chk(32'(freq_cnt_reg), 32'h4);
      for (i = 0; i < 13; i++) lw(`LS_LIST_DWELL, 32'h1);
      chk(32'(dwell_cnt_reg), 32'h10);
      nrst = 1'b0;
      tick;
      nrst = 1'b1;
      tick;
      chk(32'(freq_cnt_reg), 32'h4);
      chk(32'(pow_cnt_reg), 32'h4);
      for (i = 0; i < 4; i++) sweep(ls_trig_src_t'(i), 1'($urandom));
      sweep(LS_TRG_BUS, 1'b1);
      fstep = 32'($urandom_range(65535, 1));
      pstep = 16'($urandom_range(255, 1));
      step_cfg = '{start_freq: 32'h00100000, stop_freq: 32'h00100000 + 3 * fstep,
                   start_pow: 16'h0100, stop_pow: 16'h0100 + 3 * pstep, points: 5'h04,
                   dwell: 24'h000002};
      for (i = 0; i < 4; i++) begin
         ef[i] = 32'h00100000 + i * fstep;
         ep[i] = 16'h0100 + 16'(i) * pstep;
         mind[i] = 2;
      end
      type_step = 1'b1;
      dwell_type_step = 1'b1;
      sweep(LS_TRG_IMM, 1'b1);
      type_step = 1'b0;
      load_from_step = 1'b1;
      tick;
      load_from_step = 1'b0;
      repeat (8) tick;
      chk(32'(dwell_cnt_reg), 32'h4);
      chk(32'(freq_cnt_reg), 32'h4);
      sweep(LS_TRG_BUS, 1'b0);
      mode_manual = 1'b1;
      man_point = 5'h03;
      man_wr = 1'b1;
      tick;
      man_wr = 1'b0;
      repeat (3) tick;
      chk(freq_out_reg, ef[2]);
      chk(32'(pow_out_reg), 32'(ep[2]));
      man_point = 5'h14;
      man_wr = 1'b1;
      tick;
      man_wr = 1'b0;
      seen = 1'b0;
      repeat (3) begin
         seen = seen | man_err_reg;
         tick;
      end
      chk(32'(seen), 32'h1);
      chk(32'(man_point_reg), 32'h4);
      chk(freq_out_reg, ef[3]);
      mode_manual = 1'b0;
      final_report;
   end
endmodule
